// *** rtl/ipr_pkg.sv ***
package ipr_pkg;

  // Target address: fixed upper bits plus three strap bits
  localparam logic [3:0] ADDR_BASE_HI = 4'h5;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // Location pointer
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_MAX = 8'hFF;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

  // Readable map: index 0 flag byte, then hold-up, current, feed A, feed B, temperature
  localparam int MAP_ENTRIES = 6;
  localparam logic [5:0][7:0] MAP_LOC = {8'h28, 8'h23, 8'h22, 8'h21, 8'h1F, 8'h1E};

  // Flag byte bit positions; bits 3 and 7 read as zero
  localparam int FLAG_ENA = 0;
  localparam int FLAG_ENB = 1;
  localparam int FLAG_ALARM = 2;
  localparam int FLAG_HOLDUP = 4;
  localparam int FLAG_HOTSWAP = 5;
  localparam int FLAG_VOUT = 6;

  // Bit counter within a byte and its acknowledge slot
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  // Idle level of both bus lines
  localparam logic BUS_IDLE = 1'b1;

  typedef enum logic [7:0] {
    ST_ADDR = 8'h01,
    ST_AACK_W = 8'h02,
    ST_AACK_R = 8'h04,
    ST_WPTR = 8'h08,
    ST_WDATA = 8'h10,
    ST_RSEND = 8'h20,
    ST_RDONE = 8'h40,
    ST_IGNORE = 8'h80
  } ipr_state_t;

  typedef struct packed {
    logic enA;
    logic enB;
    logic alarm;
    logic holdupOn;
    logic hotswapOn;
    logic voutOk;
    logic [7:0] holdupV;
    logic [7:0] outCurrent;
    logic [7:0] feedAV;
    logic [7:0] feedBV;
    logic [7:0] temp;
  } ipr_meas_t;

endpackage

// *** rtl/ipr_snapshot.sv ***
module ipr_snapshot (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  // Hold values while a frame is on the bus
  input wire logic freeze,
  // Live values and lookup
  input wire ipr_pkg::ipr_meas_t meas,
  input wire logic [7:0] ptr,
  output logic [7:0] readByte
);

  logic [7:0] live [ipr_pkg::MAP_ENTRIES];
  logic [7:0] snap_r [ipr_pkg::MAP_ENTRIES];
  logic [7:0] flagByte;

  always_comb begin
    flagByte = ipr_pkg::UNMAPPED_BYTE;
    flagByte[ipr_pkg::FLAG_ENA] = meas.enA;
    flagByte[ipr_pkg::FLAG_ENB] = meas.enB;
    flagByte[ipr_pkg::FLAG_ALARM] = meas.alarm;
    flagByte[ipr_pkg::FLAG_HOLDUP] = meas.holdupOn;
    flagByte[ipr_pkg::FLAG_HOTSWAP] = meas.hotswapOn;
    flagByte[ipr_pkg::FLAG_VOUT] = meas.voutOk;
  end

  assign live[0] = flagByte;
  assign live[1] = meas.holdupV;
  assign live[2] = meas.outCurrent;
  assign live[3] = meas.feedAV;
  assign live[4] = meas.feedBV;
  assign live[5] = meas.temp;

  // Frozen during frames so the serial side never sees a byte change mid-shift
  for (genvar g = 0; g < ipr_pkg::MAP_ENTRIES; g++) begin : g_entry
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        snap_r[g] <= ipr_pkg::UNMAPPED_BYTE;
      end else if (clkEn && !freeze) begin
        snap_r[g] <= live[g];
      end
    end
  end

  always_comb begin
    readByte = ipr_pkg::UNMAPPED_BYTE;
    for (int i = 0; i < ipr_pkg::MAP_ENTRIES; i++) begin
      if (ptr == ipr_pkg::MAP_LOC[i]) begin
        readByte = snap_r[i];
      end
    end
  end

  // Judged from the map table itself, so a broken lookup loop still shows up
  AST_UNMAPPED_ZERO: assert property (@(posedge mclk) disable iff (reset)
    (ptr != ipr_pkg::MAP_LOC[0] && ptr != ipr_pkg::MAP_LOC[1] && ptr != ipr_pkg::MAP_LOC[2]
     && ptr != ipr_pkg::MAP_LOC[3] && ptr != ipr_pkg::MAP_LOC[4]
     && ptr != ipr_pkg::MAP_LOC[5]) |-> readByte == ipr_pkg::UNMAPPED_BYTE)
    else $error("unmapped location did not read zero");

endmodule // ipr_snapshot

// *** rtl/ipr_readout_port.sv ***
module ipr_readout_port (
  // Clock, reset and enable
  input wire logic mclk,
  input wire logic reset,
  input wire logic clkEn,
  // Serial bus, open drain
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Address strap
  input wire logic [2:0] addrSel,
  // Monitored values
  input wire ipr_pkg::ipr_meas_t meas
);

  logic sclM1_r, sclM2_r, sclM3_r;
  logic sdaM1_r, sdaM2_r, sdaM3_r;
  logic [2:0] strapS1_r, strapS2_r;
  logic [1:0] strapCnt_r;
  logic strapDone_r;
  logic [6:0] devAddr_r;
  logic startHold_r, busy_r;
  logic startDet, stopDet, linkClr;
  ipr_pkg::ipr_state_t state_r;
  logic [3:0] bitCnt_r;
  logic [6:0] rxSh_r;
  logic [7:0] rxByte, ptr_r, txSh_r, readByte;
  logic addrMatch, ptrWrite, ptrInc, ackSlot, ptrTouched_r, sdaOe_r;

  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_r;

  // Main clock side: bus line synchronisers and start/stop detection
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sclM1_r <= ipr_pkg::BUS_IDLE;
      sclM2_r <= ipr_pkg::BUS_IDLE;
      sclM3_r <= ipr_pkg::BUS_IDLE;
      sdaM1_r <= ipr_pkg::BUS_IDLE;
      sdaM2_r <= ipr_pkg::BUS_IDLE;
      sdaM3_r <= ipr_pkg::BUS_IDLE;
    end else if (clkEn) begin
      sclM1_r <= sclIn;
      sclM2_r <= sclM1_r;
      sclM3_r <= sclM2_r;
      sdaM1_r <= sdaIn;
      sdaM2_r <= sdaM1_r;
      sdaM3_r <= sdaM2_r;
    end
  end

  assign startDet = clkEn && sclM2_r && sclM3_r && sdaM3_r && !sdaM2_r;
  assign stopDet = clkEn && sclM2_r && sclM3_r && !sdaM3_r && sdaM2_r;

  // Start holds the serial side cleared until the clock goes low; also covers a repeated start
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      startHold_r <= 1'b0;
    end else if (startDet) begin
      startHold_r <= 1'b1;
    end else if (clkEn && !sclM2_r) begin
      startHold_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_r <= 1'b0;
    end else if (startDet) begin
      busy_r <= 1'b1;
    end else if (stopDet) begin
      busy_r <= 1'b0;
    end
  end

  // Strap caught a few cycles after release, once the synchroniser holds real pin levels
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strapS1_r <= 3'h0;
      strapS2_r <= 3'h0;
    end else if (clkEn) begin
      strapS1_r <= addrSel;
      strapS2_r <= strapS1_r;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strapCnt_r <= 2'h0;
      strapDone_r <= 1'b0;
      devAddr_r <= {ipr_pkg::ADDR_BASE_HI, 3'h0};
    end else if (clkEn && !strapDone_r) begin
      if (strapCnt_r == ipr_pkg::STRAP_WAIT) begin
        strapDone_r <= 1'b1;
        devAddr_r <= {ipr_pkg::ADDR_BASE_HI, strapS2_r};
      end else begin
        strapCnt_r <= strapCnt_r + 2'h1;
      end
    end
  end

  // Async clear is a held level released while the bus clock is low, so recovery is safe
  assign linkClr = reset || startHold_r;

  ipr_snapshot u_snapshot (
    .mclk(mclk),
    .reset(reset),
    .clkEn(clkEn),
    .freeze(busy_r),
    .meas(meas),
    .ptr(ptr_r),
    .readByte(readByte)
  );

  // Link side: rising edge samples data and steps the byte state
  assign rxByte = {rxSh_r, sdaIn};
  assign addrMatch = rxByte[7:1] == devAddr_r;

  always_ff @(posedge sclIn or posedge linkClr) begin
    if (linkClr) begin
      bitCnt_r <= ipr_pkg::BIT_FIRST;
      rxSh_r <= 7'h00;
    end else begin
      rxSh_r <= rxByte[6:0];
      if (bitCnt_r == ipr_pkg::BIT_ACK) begin
        bitCnt_r <= ipr_pkg::BIT_FIRST;
      end else begin
        bitCnt_r <= bitCnt_r + ipr_pkg::BIT_STEP;
      end
    end
  end

  always_ff @(posedge sclIn or posedge linkClr) begin
    if (linkClr) begin
      state_r <= ipr_pkg::ST_ADDR;
    end else if (bitCnt_r == ipr_pkg::BIT_LAST) begin
      unique case (state_r)
        ipr_pkg::ST_ADDR: begin
          if (!addrMatch) begin
            state_r <= ipr_pkg::ST_IGNORE;
          end else if (rxByte[0]) begin
            state_r <= ipr_pkg::ST_AACK_R;
          end else begin
            state_r <= ipr_pkg::ST_AACK_W;
          end
        end
        ipr_pkg::ST_WPTR: state_r <= ipr_pkg::ST_WDATA;
        ipr_pkg::ST_AACK_W, ipr_pkg::ST_AACK_R, ipr_pkg::ST_WDATA, ipr_pkg::ST_RSEND,
        ipr_pkg::ST_RDONE, ipr_pkg::ST_IGNORE: state_r <= state_r;
      endcase
    end else if (bitCnt_r == ipr_pkg::BIT_ACK) begin
      unique case (state_r)
        ipr_pkg::ST_AACK_W: state_r <= ipr_pkg::ST_WPTR;
        ipr_pkg::ST_AACK_R: state_r <= ipr_pkg::ST_RSEND;
        ipr_pkg::ST_RSEND: begin
          if (sdaIn) begin
            state_r <= ipr_pkg::ST_RDONE;
          end
        end
        ipr_pkg::ST_ADDR, ipr_pkg::ST_WPTR, ipr_pkg::ST_WDATA, ipr_pkg::ST_RDONE,
        ipr_pkg::ST_IGNORE: state_r <= state_r;
      endcase
    end
  end

  // Pointer survives frames; only power-on reset clears it
  assign ptrWrite = state_r == ipr_pkg::ST_WPTR && bitCnt_r == ipr_pkg::BIT_LAST;
  assign ptrInc = (state_r == ipr_pkg::ST_WDATA && bitCnt_r == ipr_pkg::BIT_LAST)
    || (state_r == ipr_pkg::ST_RSEND && bitCnt_r == ipr_pkg::BIT_ACK);

  always_ff @(posedge sclIn or posedge reset) begin
    if (reset) begin
      ptr_r <= ipr_pkg::PTR_RESET;
    end else if (ptrWrite) begin
      ptr_r <= rxByte;
    end else if (ptrInc && ptr_r != ipr_pkg::PTR_MAX) begin
      ptr_r <= ptr_r + ipr_pkg::PTR_STEP;
    end
  end

  always_ff @(posedge sclIn or posedge reset) begin
    if (reset) begin
      ptrTouched_r <= 1'b0;
    end else if (ptrWrite || ptrInc) begin
      ptrTouched_r <= 1'b1;
    end
  end

  // Link side: falling edge drives acknowledge and read data
  assign ackSlot = state_r == ipr_pkg::ST_AACK_W || state_r == ipr_pkg::ST_AACK_R
    || state_r == ipr_pkg::ST_WDATA;

  always_ff @(negedge sclIn or posedge linkClr) begin
    if (linkClr) begin
      sdaOe_r <= 1'b0;
      txSh_r <= ipr_pkg::UNMAPPED_BYTE;
    end else if (bitCnt_r == ipr_pkg::BIT_ACK) begin
      sdaOe_r <= ackSlot;
    end else if (state_r == ipr_pkg::ST_RSEND) begin
      if (bitCnt_r == ipr_pkg::BIT_FIRST) begin
        txSh_r <= readByte;
        sdaOe_r <= !readByte[7];
      end else begin
        sdaOe_r <= !txSh_r[3'(ipr_pkg::BIT_LAST - bitCnt_r)];
      end
    end else begin
      sdaOe_r <= 1'b0;
    end
  end

  sequence s_hostNack;
    state_r == ipr_pkg::ST_RSEND && bitCnt_r == ipr_pkg::BIT_ACK && sdaIn;
  endsequence

  sequence s_released;
    state_r == ipr_pkg::ST_RDONE ##1 !sdaOe_r;
  endsequence

  AST_PTR_POWERON: assert property (@(posedge sclIn) disable iff (reset)
    !ptrTouched_r |-> ptr_r == ipr_pkg::PTR_RESET)
    else $error("pointer not zero before first update");

  AST_PTR_SAT: assert property (@(posedge sclIn) disable iff (reset)
    (ptrInc && ptr_r == ipr_pkg::PTR_MAX) |=> ptr_r == ipr_pkg::PTR_MAX)
    else $error("pointer wrapped past maximum");

  AST_PTR_READ_INC: assert property (@(posedge sclIn) disable iff (reset)
    (state_r == ipr_pkg::ST_RSEND && bitCnt_r == ipr_pkg::BIT_ACK
     && ptr_r != ipr_pkg::PTR_MAX) |=> ptr_r == $past(ptr_r) + ipr_pkg::PTR_STEP)
    else $error("pointer did not advance after a read byte");

  AST_PTR_WRITE_INC: assert property (@(posedge sclIn) disable iff (reset)
    (state_r == ipr_pkg::ST_WDATA && bitCnt_r == ipr_pkg::BIT_LAST
     && ptr_r != ipr_pkg::PTR_MAX) |=> ptr_r == $past(ptr_r) + ipr_pkg::PTR_STEP)
    else $error("pointer did not advance after an extra written byte");

  AST_ACK_DRIVEN: assert property (@(posedge sclIn) disable iff (linkClr)
    (bitCnt_r == ipr_pkg::BIT_ACK && ackSlot) |-> sdaOe_r)
    else $error("address or written byte not acknowledged");

  AST_IGNORE_QUIET: assert property (@(posedge sclIn) disable iff (linkClr)
    state_r == ipr_pkg::ST_IGNORE |-> !sdaOe_r)
    else $error("drove the bus for another target");

  AST_FIRST_BYTE: assert property (@(posedge sclIn) disable iff (linkClr)
    (state_r == ipr_pkg::ST_RSEND && bitCnt_r == ipr_pkg::BIT_FIRST)
    |-> (txSh_r == readByte && sdaOe_r == !readByte[7]))
    else $error("read byte is not the selected location");

  AST_NACK_ENDS: assert property (@(posedge sclIn) disable iff (linkClr)
    s_hostNack |=> s_released)
    else $error("kept driving after host nack");

  AST_START_CLEARS: assert property (@(posedge mclk) disable iff (reset)
    startDet |=> startHold_r && state_r == ipr_pkg::ST_ADDR)
    else $error("start did not restart address phase");

  AST_STRAP_ADDR: assert property (@(posedge mclk) disable iff (reset)
    $rose(strapDone_r) |-> devAddr_r == {ipr_pkg::ADDR_BASE_HI, $past(strapS2_r)})
    else $error("target address not taken from strap");

endmodule // ipr_readout_port

// *** tb/ipr_host_model.sv ***
module ipr_host_model (
  // Bus clock and data pull
  output logic scl,
  output logic sdaLow,
  // Resolved data line
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // Half period of the 64 ns bus clock
  int half = 32;

  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end

  // Long high and low phases around a start so the sampled bus sees it
  task automatic start();
    if (scl === 1'b0) begin
      #4 sdaLow = 1'b0;
      #(half) scl = 1'b1;
    end
    #150 sdaLow = 1'b1;
    #150 scl = 1'b0;
    #150;
  endtask

  // Data only moves while the clock is low
  task automatic bitCycle(input logic drv, output logic seen);
    #4 sdaLow = ~drv;
    #(half - 4) scl = 1'b1;
    seen = sda;
    #(half) scl = 1'b0;
  endtask

  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitCycle(b[i], s);
    bitCycle(1'b1, s);
    ack = ~s;
  endtask

  task automatic rdByte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'b1, s);
      b[i] = s;
    end
    bitCycle(last, s);
  endtask

  // Clock then stands still high outside frames
  task automatic stop();
    #4 sdaLow = 1'b1;
    #(half) scl = 1'b1;
    #150 sdaLow = 1'b0;
    #300;
  endtask
endmodule // ipr_host_model

// *** tb/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset, clkEn, sdaOut, sdaOe, scl, hostLow, sdaBus;
  logic [2:0] addrSel;
  logic [6:0] devAddr = 7'h2D;
  ipr_pkg::ipr_meas_t meas;
  int errors = 0;
  int checksDone = 0;
  logic [7:0] rd[$];

  // Open drain line with pull-up
  assign sdaBus = (hostLow | (sdaOe & ~sdaOut)) ? 1'b0 : 1'b1;

  ipr_readout_port dut_u (.mclk(mclk), .reset(reset), .clkEn(clkEn), .sclIn(scl),
    .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel), .meas(meas));
  ipr_host_model host_u (.scl(scl), .sdaLow(hostLow), .sda(sdaBus));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [7:0] mapVal(input logic [7:0] p);
    case (p)
      8'h1E: mapVal = 8'h55;
      8'h1F: mapVal = 8'hA3;
      8'h21: mapVal = 8'h3C;
      8'h22: mapVal = 8'h96;
      8'h23: mapVal = 8'h69;
      8'h28: mapVal = 8'hC7;
      default: mapVal = 8'h00;
    endcase
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic doReset();
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic sendAddr(input logic [6:0] a, input logic rdBit, input logic expAck);
    logic ack;
    host_u.start();
    host_u.wrByte({a, rdBit}, ack);
    chk("address ack", {7'h0, expAck}, {7'h0, ack});
  endtask

  task automatic wrPtr(input logic [7:0] p, input int extra, input logic withStop);
    logic ack;
    sendAddr(devAddr, 1'b0, 1'b1);
    host_u.wrByte(p, ack);
    chk("pointer ack", 8'h01, {7'h0, ack});
    for (int i = 0; i < extra; i++) begin
      host_u.wrByte(8'hA5 ^ i[7:0], ack);
      chk("extra byte ack", 8'h01, {7'h0, ack});
    end
    if (withStop) host_u.stop();
  endtask

  task automatic rdN(input int n);
    logic [7:0] b;
    rd.delete();
    sendAddr(devAddr, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      host_u.rdByte(i == n - 1, b);
      rd.push_back(b);
    end
    host_u.stop();
    chk("released data line", 8'h00, {7'h0, sdaOe});
  endtask

  task automatic t_strap();
    for (int s = 0; s < 8; s++) begin
      @(posedge mclk);
      addrSel <= s[2:0];
      doReset();
      sendAddr(7'h28 | {4'h0, s[2:0]}, 1'b0, 1'b1);
      host_u.stop();
      sendAddr(7'h28 | {4'h0, s[2:0] ^ 3'h1}, 1'b0, 1'b0);
      host_u.stop();
    end
    @(posedge mclk);
    addrSel <= 3'h5;
    doReset();
    $display("test strap done");
  endtask

  task automatic t_power_on();
    wrPtr(8'h1E, 0, 1'b1);
    doReset();
    rdN(1);
    chk("pointer after reset", 8'h00, rd[0]);
    $display("test power_on done");
  endtask

  // Pointer write closed by a repeated start, then a long sweep
  task automatic t_map();
    wrPtr(8'h1D, 0, 1'b0);
    rdN(13);
    for (int i = 0; i < 13; i++) begin
      chk("map byte", mapVal(8'h1D + i[7:0]), rd[i]);
    end
    $display("test map done");
  endtask

  task automatic t_extra();
    wrPtr(8'h1C, 2, 1'b1);
    rdN(1);
    chk("byte after extra writes", 8'h55, rd[0]);
    rdN(1);
    chk("byte after nacked read", 8'hA3, rd[0]);
    $display("test extra done");
  endtask

  // A wrap on either path would bring the flag byte back within 32 reads
  task automatic t_saturate();
    wrPtr(8'hFE, 2, 1'b0);
    rdN(32);
    for (int i = 0; i < 32; i++) chk("byte past top", 8'h00, rd[i]);
    $display("test saturate done");
  endtask

  initial begin
    clkEn = 1'b1;
    reset = 1'b1;
    addrSel = 3'h5;
    meas = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 8'hA3, 8'h3C, 8'h96, 8'h69, 8'hC7};
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (8) @(posedge mclk);
    t_strap();
    t_power_on();
    t_map();
    t_extra();
    t_saturate();
    stop_test();
  end

  initial begin
    #500000;
    errors++;
    $display("unexpected watchdog: expected end, seen hang");
    stop_test();
  end
endmodule // tb
